//--- rtl/qcis_map.vh
// register map, field positions and reset values of the queue interrupt block
`ifndef QCIS_MAP_VH
`define QCIS_MAP_VH

// host bus geometry, queue count and counter count
`define QCIS_ADDR_W          9
`define QCIS_DATA_W          32
`define QCIS_NUM_QUEUES      8
`define QCIS_NUM_CNT         32

// register byte offsets
`define QCIS_OFF_QEV_STAT    9'h1c0
`define QCIS_OFF_QEV_MASK    9'h1c4
`define QCIS_OFF_QOU_STAT    9'h1c8
`define QCIS_OFF_QOU_MASK    9'h1cc
`define QCIS_OFF_TXR_STAT    9'h1d0
`define QCIS_OFF_TXR_MASK    9'h1d4
`define QCIS_OFF_RXR_STAT    9'h1d8
`define QCIS_OFF_RXR_MASK    9'h1dc

// reset values
`define QCIS_RST_STAT        32'h0000_0000
`define QCIS_RST_MASK        32'h0000_0000
`define QCIS_RD_UNMAPPED     32'h0000_0000

// per-queue group inside the queue event status word
`define QCIS_GRP_W           4
`define QCIS_QEV_RDY_RISE    3
`define QCIS_QEV_RDY_FALL    2
`define QCIS_QEV_A_RISE      1
`define QCIS_QEV_B_RISE      0

// per-queue group inside the overflow/underrun word
`define QCIS_QOU_OVFL        3
`define QCIS_QOU_UNDR        2

// host interrupt summary bit positions
`define QCIS_SUM_QEV         19
`define QCIS_SUM_QOU         18
`define QCIS_SUM_STATS       16

`endif

//--- rtl/qcis_edge_det.v
// edge detector for a vector of same-clock flags
`timescale 1ns/1ps

module qcis_edge_det #(
    parameter W = 8
) (
    input  wire         clk_i,
    input  wire         srst_i,
    input  wire         ce_i,
    input  wire [W-1:0] flag_i,
    output wire [W-1:0] rise_o,
    output wire [W-1:0] fall_o
);

    reg [W-1:0] prev_reg;

    // previous value starts at zero, so a flag already high after reset
    // is reported once as a rising edge
    always @(posedge clk_i) begin
        if (srst_i) begin
            prev_reg <= {W{1'b0}};
        end else if (ce_i) begin
            prev_reg <= flag_i;
        end
    end

    // edges only count while enabled, otherwise a frozen block would
    // report the same edge again on every stalled cycle
    assign rise_o = (flag_i & ~prev_reg) & {W{ce_i}};
    assign fall_o = (~flag_i & prev_reg) & {W{ce_i}};

endmodule // qcis_edge_det

//--- rtl/qcis_event_reg.v
// sticky clear-on-read status word with its forwarding mask
`timescale 1ns/1ps

module qcis_event_reg #(
    parameter W = 32
) (
    input  wire         clk_i,
    input  wire         srst_i,
    input  wire         ce_i,
    input  wire [W-1:0] set_i,
    input  wire         clr_i,
    input  wire         mask_wr_i,
    input  wire [W-1:0] mask_wdata_i,
    output wire [W-1:0] status_o,
    output wire [W-1:0] mask_o,
    output wire         pend_o
);

    reg  [W-1:0] status_reg;
    reg  [W-1:0] mask_reg;
    wire [W-1:0] status_next;

    // set wins over the read clear, so no event is lost
    assign status_next = (clr_i ? {W{1'b0}} : status_reg) | set_i;

    always @(posedge clk_i) begin
        if (srst_i) begin
            status_reg <= {W{1'b0}};
            mask_reg   <= {W{1'b0}};
        end else if (ce_i) begin
            status_reg <= status_next;
            if (mask_wr_i) begin
                mask_reg <= mask_wdata_i;
            end
        end
    end

    assign status_o = status_reg;
    assign mask_o   = mask_reg;
    assign pend_o   = |(status_reg & mask_reg);

endmodule // qcis_event_reg

//--- rtl/qcis_top.v
// queue event, overflow/underrun and counter rollover interrupt status
`timescale 1ns/1ps
`include "qcis_map.vh"

// Behaviour
// - queue 7 ready rise sets bit 31
// - queue 7 ready fall sets bit 30
// - queue 7 flag A/B rises set 29/28
// - queue n group at bits 4n+3..4n
// - reading any status register clears it
// - queue event mask forwards to summary
// - queue 7 overflow bit 31, underrun 30
// - queue n pairs, lower pair reads zero
// - overflow/underrun mask forwards to summary
// - tx counter n rollover sets bit n
// - tx rollover mask forwards to summary
// - rx counter n+32 rollover sets bit n
// - rx rollover mask forwards to summary
// - summary bits follow sources, read-proof
module qcis_top (
    input  wire                    clk_i,
    input  wire                    srst_i,
    input  wire                    ce_i,
    // host register port
    input  wire [`QCIS_ADDR_W-1:0] host_addr_i,
    input  wire                    host_rd_i,
    input  wire                    host_wr_i,
    input  wire [`QCIS_DATA_W-1:0] host_wdata_i,
    output wire [`QCIS_DATA_W-1:0] host_rdata_o,
    output wire                    host_rvalid_o,
    // queue engine flags and events
    input  wire [7:0]              queue_data_ready_flag_i,
    input  wire [7:0]              queue_status_flag_a_i,
    input  wire [7:0]              queue_status_flag_b_i,
    input  wire [7:0]              queue_overflow_i,
    input  wire [7:0]              queue_underrun_i,
    // statistics counter wrap pulses
    input  wire [31:0]             tx_counter_rollover_i,
    input  wire [31:0]             rx_counter_rollover_i,
    // summary bits toward the host interrupt register
    output wire [31:0]             host_interrupt_summary_o,
    output wire                    summary_queue_event_o,
    output wire                    summary_overflow_underrun_o,
    output wire                    summary_statistics_o
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    localparam NQ = `QCIS_NUM_QUEUES;
    localparam GW = `QCIS_GRP_W;

    wire [NQ-1:0]              rdy_rise;
    wire [NQ-1:0]              rdy_fall;
    wire [NQ-1:0]              flag_a_rise;
    wire [NQ-1:0]              flag_b_rise;
    wire [NQ-1:0]              flag_a_fall_unused;
    wire [NQ-1:0]              flag_b_fall_unused;

    reg  [`QCIS_DATA_W-1:0]    qev_set;
    reg  [`QCIS_DATA_W-1:0]    qou_set;
    wire [`QCIS_DATA_W-1:0]    txr_set;
    wire [`QCIS_DATA_W-1:0]    rxr_set;

    wire [`QCIS_DATA_W-1:0]    qev_status;
    wire [`QCIS_DATA_W-1:0]    qev_mask;
    wire [`QCIS_DATA_W-1:0]    qou_status;
    wire [`QCIS_DATA_W-1:0]    qou_mask;
    wire [`QCIS_DATA_W-1:0]    txr_status;
    wire [`QCIS_DATA_W-1:0]    txr_mask;
    wire [`QCIS_DATA_W-1:0]    rxr_status;
    wire [`QCIS_DATA_W-1:0]    rxr_mask;

    wire                       qev_pend;
    wire                       qou_pend;
    wire                       txr_pend;
    wire                       rxr_pend;

    wire                       rd_take;
    wire                       wr_take;
    wire                       hit_qev_stat;
    wire                       hit_qev_mask;
    wire                       hit_qou_stat;
    wire                       hit_qou_mask;
    wire                       hit_txr_stat;
    wire                       hit_txr_mask;
    wire                       hit_rxr_stat;
    wire                       hit_rxr_mask;

    reg  [`QCIS_DATA_W-1:0]    rdata_next;
    reg  [`QCIS_DATA_W-1:0]    rdata_reg;
    reg                        rvalid_reg;
    reg  [31:0]                summary_reg;
    wire [31:0]                summary_next;

    integer                    q;

    // ------------------------------------------------------------------
    // edge detection on the queue flags
    // ------------------------------------------------------------------
    qcis_edge_det #(
        .W (NQ)
    ) u_rdy_edge (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .ce_i   (ce_i),
        .flag_i (queue_data_ready_flag_i),
        .rise_o (rdy_rise),
        .fall_o (rdy_fall)
    );

    // flag falls are not events here; only rises are latched
    qcis_edge_det #(
        .W (NQ)
    ) u_a_edge (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .ce_i   (ce_i),
        .flag_i (queue_status_flag_a_i),
        .rise_o (flag_a_rise),
        .fall_o (flag_a_fall_unused)
    );

    qcis_edge_det #(
        .W (NQ)
    ) u_b_edge (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .ce_i   (ce_i),
        .flag_i (queue_status_flag_b_i),
        .rise_o (flag_b_rise),
        .fall_o (flag_b_fall_unused)
    );

    // ------------------------------------------------------------------
    // placement of events into the status words
    // ------------------------------------------------------------------
    always @* begin
        qev_set = `QCIS_RST_STAT;
        qou_set = `QCIS_RST_STAT;
        for (q = 0; q < NQ; q = q + 1) begin
            qev_set[q*GW + `QCIS_QEV_RDY_RISE] = rdy_rise[q];
            qev_set[q*GW + `QCIS_QEV_RDY_FALL] = rdy_fall[q];
            qev_set[q*GW + `QCIS_QEV_A_RISE]   = flag_a_rise[q];
            qev_set[q*GW + `QCIS_QEV_B_RISE]   = flag_b_rise[q];
            // the two bits below each pair stay zero as reserved
            qou_set[q*GW + `QCIS_QOU_OVFL] =
                queue_overflow_i[q] & ce_i;
            qou_set[q*GW + `QCIS_QOU_UNDR] =
                queue_underrun_i[q] & ce_i;
        end
    end

    // counter wraps are one-cycle pulses; gated so a stall cannot
    // let the frozen register miss them silently twice
    assign txr_set = tx_counter_rollover_i & {32{ce_i}};
    // rx counter index n+32 arrives on input bit n
    assign rxr_set = rx_counter_rollover_i & {32{ce_i}};

    // ------------------------------------------------------------------
    // host register decode
    // ------------------------------------------------------------------
    assign rd_take = host_rd_i & ce_i;
    assign wr_take = host_wr_i & ce_i & ~host_rd_i;

    assign hit_qev_stat = (host_addr_i == `QCIS_OFF_QEV_STAT);
    assign hit_qev_mask = (host_addr_i == `QCIS_OFF_QEV_MASK);
    assign hit_qou_stat = (host_addr_i == `QCIS_OFF_QOU_STAT);
    assign hit_qou_mask = (host_addr_i == `QCIS_OFF_QOU_MASK);
    assign hit_txr_stat = (host_addr_i == `QCIS_OFF_TXR_STAT);
    assign hit_txr_mask = (host_addr_i == `QCIS_OFF_TXR_MASK);
    assign hit_rxr_stat = (host_addr_i == `QCIS_OFF_RXR_STAT);
    assign hit_rxr_mask = (host_addr_i == `QCIS_OFF_RXR_MASK);

    // ------------------------------------------------------------------
    // status and mask registers
    // ------------------------------------------------------------------
    // clear on read; a same-cycle set survives inside the register
    qcis_event_reg #(
        .W (`QCIS_DATA_W)
    ) u_qev (
        .clk_i        (clk_i),
        .srst_i       (srst_i),
        .ce_i         (ce_i),
        .set_i        (qev_set),
        .clr_i        (rd_take & hit_qev_stat),
        .mask_wr_i    (wr_take & hit_qev_mask),
        .mask_wdata_i (host_wdata_i),
        .status_o     (qev_status),
        .mask_o       (qev_mask),
        .pend_o       (qev_pend)
    );

    qcis_event_reg #(
        .W (`QCIS_DATA_W)
    ) u_qou (
        .clk_i        (clk_i),
        .srst_i       (srst_i),
        .ce_i         (ce_i),
        .set_i        (qou_set),
        .clr_i        (rd_take & hit_qou_stat),
        .mask_wr_i    (wr_take & hit_qou_mask),
        .mask_wdata_i (host_wdata_i),
        .status_o     (qou_status),
        .mask_o       (qou_mask),
        .pend_o       (qou_pend)
    );

    qcis_event_reg #(
        .W (`QCIS_DATA_W)
    ) u_txr (
        .clk_i        (clk_i),
        .srst_i       (srst_i),
        .ce_i         (ce_i),
        .set_i        (txr_set),
        .clr_i        (rd_take & hit_txr_stat),
        .mask_wr_i    (wr_take & hit_txr_mask),
        .mask_wdata_i (host_wdata_i),
        .status_o     (txr_status),
        .mask_o       (txr_mask),
        .pend_o       (txr_pend)
    );

    qcis_event_reg #(
        .W (`QCIS_DATA_W)
    ) u_rxr (
        .clk_i        (clk_i),
        .srst_i       (srst_i),
        .ce_i         (ce_i),
        .set_i        (rxr_set),
        .clr_i        (rd_take & hit_rxr_stat),
        .mask_wr_i    (wr_take & hit_rxr_mask),
        .mask_wdata_i (host_wdata_i),
        .status_o     (rxr_status),
        .mask_o       (rxr_mask),
        .pend_o       (rxr_pend)
    );

    // ------------------------------------------------------------------
    // read data path
    // ------------------------------------------------------------------
    // the value returned is the one held before the clearing edge
    always @* begin
        rdata_next = `QCIS_RD_UNMAPPED;
        case (1'b1)
            hit_qev_stat: rdata_next = qev_status;
            hit_qev_mask: rdata_next = qev_mask;
            hit_qou_stat: rdata_next = qou_status;
            hit_qou_mask: rdata_next = qou_mask;
            hit_txr_stat: rdata_next = txr_status;
            hit_txr_mask: rdata_next = txr_mask;
            hit_rxr_stat: rdata_next = rxr_status;
            hit_rxr_mask: rdata_next = rxr_mask;
            default:      rdata_next = `QCIS_RD_UNMAPPED;
        endcase
    end

    always @(posedge clk_i) begin
        if (srst_i) begin
            rdata_reg  <= `QCIS_RD_UNMAPPED;
            rvalid_reg <= 1'b0;
        end else if (ce_i) begin
            rvalid_reg <= host_rd_i;
            if (host_rd_i) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    assign host_rdata_o  = rdata_reg;
    assign host_rvalid_o = rvalid_reg;

    // ------------------------------------------------------------------
    // host interrupt summary
    // ------------------------------------------------------------------
    // level bits: they drop only when the status bits behind them are
    // read away or masked off, never by a read of the summary itself
    assign summary_next = (32'h0000_0001 << `QCIS_SUM_QEV)
                              & {32{qev_pend}}
                        | (32'h0000_0001 << `QCIS_SUM_QOU)
                              & {32{qou_pend}}
                        | (32'h0000_0001 << `QCIS_SUM_STATS)
                              & {32{txr_pend | rxr_pend}};

    always @(posedge clk_i) begin
        if (srst_i) begin
            summary_reg <= 32'h0000_0000;
        end else if (ce_i) begin
            summary_reg <= summary_next;
        end
    end

    assign host_interrupt_summary_o    = summary_reg;
    assign summary_queue_event_o       = summary_reg[`QCIS_SUM_QEV];
    assign summary_overflow_underrun_o = summary_reg[`QCIS_SUM_QOU];
    assign summary_statistics_o        = summary_reg[`QCIS_SUM_STATS];

endmodule // qcis_top

//--- bench/qcis_monitor.sv
// concurrent checks on the ports of the queue interrupt status block
`timescale 1ns/1ps

module qcis_monitor (
    input wire        clk_i,
    input wire        srst_i,
    input wire        ce_i,
    input wire [8:0]  host_addr_i,
    input wire        host_rd_i,
    input wire        host_wr_i,
    input wire [31:0] host_rdata_o,
    input wire        host_rvalid_o,
    input wire [7:0]  queue_data_ready_flag_i,
    input wire [7:0]  queue_status_flag_a_i,
    input wire [7:0]  queue_status_flag_b_i,
    input wire [7:0]  queue_overflow_i,
    input wire [31:0] tx_counter_rollover_i,
    input wire [31:0] host_interrupt_summary_o,
    input wire        summary_queue_event_o,
    input wire        summary_overflow_underrun_o,
    input wire        summary_statistics_o
);
    wire        rd_qev = ce_i && host_rd_i && host_addr_i == 9'h1c0;
    wire        rd_qou = ce_i && host_rd_i && host_addr_i == 9'h1c8;
    wire        rd_txr = ce_i && host_rd_i && host_addr_i == 9'h1d0;
    wire [23:0] flags  = {queue_data_ready_flag_i, queue_status_flag_a_i,
                          queue_status_flag_b_i};

    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);

    read_answer_a: assert property (
        ce_i |=> host_rvalid_o == $past(host_rd_i))
        else $error("read answer pulse wrong");
    summary_copy_a: assert property (
        summary_queue_event_o == host_interrupt_summary_o[19] &&
        summary_overflow_underrun_o == host_interrupt_summary_o[18] &&
        summary_statistics_o == host_interrupt_summary_o[16] &&
        (host_interrupt_summary_o & 32'hfff2_ffff) == 32'h0)
        else $error("summary word inconsistent");
    q7_rise_a: assert property (
        ce_i && $rose(queue_data_ready_flag_i[7]) ##1 rd_qev
        |=> host_rdata_o[31])
        else $error("ready rise not reported");
    q7_fall_a: assert property (
        ce_i && $fell(queue_data_ready_flag_i[7]) ##1 rd_qev
        |=> host_rdata_o[30])
        else $error("ready fall not reported");
    q7_overflow_a: assert property (
        ce_i && queue_overflow_i[7] ##1 rd_qou |=> host_rdata_o[31])
        else $error("overflow not reported");
    pair_reserved_a: assert property (
        rd_qou |=> (host_rdata_o & 32'h3333_3333) == 32'h0)
        else $error("reserved pair not zero");
    tx_rollover_a: assert property (
        ce_i && tx_counter_rollover_i[0] ##1 rd_txr |=> host_rdata_o[0])
        else $error("rollover not reported");
    clear_read_a: assert property (
        rd_qev && $stable(flags) ##1 $stable(flags) ##1
        rd_qev && $stable(flags) |=> host_rdata_o == 32'h0)
        else $error("status not cleared by read");
    summary_hold_a: assert property (
        summary_statistics_o && ce_i && !host_rd_i && !host_wr_i &&
        !$past(host_rd_i) && !$past(host_wr_i) |=> summary_statistics_o)
        else $error("summary dropped without clear");
endmodule // qcis_monitor

bind qcis_top qcis_monitor u_qcis_monitor (
    .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
    .host_addr_i(host_addr_i), .host_rd_i(host_rd_i),
    .host_wr_i(host_wr_i), .host_rdata_o(host_rdata_o),
    .host_rvalid_o(host_rvalid_o),
    .queue_data_ready_flag_i(queue_data_ready_flag_i),
    .queue_status_flag_a_i(queue_status_flag_a_i),
    .queue_status_flag_b_i(queue_status_flag_b_i),
    .queue_overflow_i(queue_overflow_i),
    .tx_counter_rollover_i(tx_counter_rollover_i),
    .host_interrupt_summary_o(host_interrupt_summary_o),
    .summary_queue_event_o(summary_queue_event_o),
    .summary_overflow_underrun_o(summary_overflow_underrun_o),
    .summary_statistics_o(summary_statistics_o)
);

//--- bench/qcis_top_tb.sv
// self-checking bench for the queue interrupt status block
`timescale 1ns/1ps

module qcis_top_tb;
    reg         clk_i = 1'b0;
    reg         srst_i = 1'b1;
    reg         ce_i = 1'b1;
    reg  [8:0]  host_addr_i = 9'h0;
    reg         host_rd_i = 1'b0;
    reg         host_wr_i = 1'b0;
    reg  [31:0] host_wdata_i = 32'h0;
    reg  [7:0]  rdy = 8'h0;
    reg  [7:0]  fa = 8'h0;
    reg  [7:0]  fb = 8'h0;
    reg  [7:0]  ovf = 8'h0;
    reg  [7:0]  udr = 8'h0;
    reg  [31:0] txr = 32'h0;
    reg  [31:0] rxr = 32'h0;
    wire [31:0] rdata;
    wire        rvalid;
    wire [31:0] summ;
    integer     err_total = 0;
    integer     tests_run = 0;

    qcis_top u_qcis_top (
        .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
        .host_addr_i(host_addr_i), .host_rd_i(host_rd_i),
        .host_wr_i(host_wr_i), .host_wdata_i(host_wdata_i),
        .host_rdata_o(rdata), .host_rvalid_o(rvalid),
        .queue_data_ready_flag_i(rdy), .queue_status_flag_a_i(fa),
        .queue_status_flag_b_i(fb), .queue_overflow_i(ovf),
        .queue_underrun_i(udr), .tx_counter_rollover_i(txr),
        .rx_counter_rollover_i(rxr), .host_interrupt_summary_o(summ),
        .summary_queue_event_o(), .summary_overflow_underrun_o(),
        .summary_statistics_o()
    );

    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------
    // bus and compare helpers; all but chk are entered and left at a rising edge
    // ------------------------------------------------------------
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("CHECK FAILED t=%0t seen=%h exp=%h",
                         $time, seen, exp);
            end
        end
    endtask

    task rc(input [8:0] a, input [31:0] e);
        begin
            host_addr_i <= a;
            host_rd_i <= 1'b1;
            @(posedge clk_i);
            host_rd_i <= 1'b0;
            @(negedge clk_i);
            chk({31'h0, rvalid}, 32'h1);
            chk(rdata, e);
            @(posedge clk_i);
        end
    endtask

    task wr(input [8:0] a, input [31:0] d);
        begin
            host_addr_i <= a;
            host_wdata_i <= d;
            host_wr_i <= 1'b1;
            @(posedge clk_i);
            host_wr_i <= 1'b0;
        end
    endtask

    // one cycle of an event source; level flags drop again, so they fall
    task ev(input [2:0] k, input [31:0] v);
        begin
            case (k)
                3'd0: rdy <= v[31:24] | v[7:0];
                3'd1: ovf <= v[31:24] | v[7:0];
                3'd3: txr <= v;
                default: rxr <= v;
            endcase
            @(posedge clk_i);
            rdy <= 8'h0;
            ovf <= 8'h0;
            txr <= 32'h0;
            rxr <= 32'h0;
        end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task s_reset;
        reg [8:0] a;
        begin
            for (a = 9'h1c0; a < 9'h1e0; a = a + 9'h4) begin
                rc(a, 32'h0);
            end
            wr(9'h1c0, 32'hffff_ffff);
            rc(9'h1c0, 32'h0);
            rc(9'h1e0, 32'h0);
            @(negedge clk_i);
            chk(summ, 32'h0);
            @(posedge clk_i);
        end
    endtask

    task s_qev;
        integer q;
        begin
            for (q = 0; q < 8; q = q + 1) begin
                rdy <= 8'h1 << q;
                fa <= 8'h1 << q;
                fb <= 8'h1 << q;
                @(posedge clk_i);
                rc(9'h1c0, 32'hb << (4 * q));
                rdy <= 8'h0;
                fa <= 8'h0;
                fb <= 8'h0;
                @(posedge clk_i);
                rc(9'h1c0, 32'h4 << (4 * q));
                rc(9'h1c0, 32'h0);
            end
        end
    endtask

    task s_ovu;
        integer q;
        begin
            for (q = 0; q < 8; q = q + 1) begin
                udr <= 8'h1 << q;
                @(posedge clk_i);
                udr <= 8'h0;
                // overflow last, so the read follows it straight away
                ev(3'd1, 32'h1 << q);
                rc(9'h1c8, 32'hc << (4 * q));
            end
            rc(9'h1c8, 32'h0);
        end
    endtask

    task s_roll;
        begin
            ev(3'd3, 32'h1234_5679);
            rc(9'h1d0, 32'h1234_5679);
            ev(3'd4, 32'h8421_0f0f);
            rc(9'h1d8, 32'h8421_0f0f);
            rc(9'h1d0, 32'h0);
        end
    endtask

    // a wrap in the very cycle of the clearing read must survive
    task s_race;
        begin
            host_addr_i <= 9'h1d0;
            host_rd_i <= 1'b1;
            txr <= 32'h20;
            @(posedge clk_i);
            host_rd_i <= 1'b0;
            txr <= 32'h0;
            @(negedge clk_i);
            chk(rdata, 32'h0);
            @(posedge clk_i);
            rc(9'h1d0, 32'h20);
        end
    endtask

    // a wrap and a mask write while the enable is low are both lost
    task s_freeze;
        begin
            ce_i <= 1'b0;
            txr <= 32'h4;
            host_addr_i <= 9'h1d4;
            host_wdata_i <= 32'hffff_ffff;
            host_wr_i <= 1'b1;
            @(posedge clk_i);
            ce_i <= 1'b1;
            txr <= 32'h0;
            host_wr_i <= 1'b0;
            rc(9'h1d4, 32'h0);
            rc(9'h1d0, 32'h0);
        end
    endtask

    task s_mask(input [8:0] ma, input [2:0] k, input [4:0] sb,
                input [31:0] e);
        begin
            wr(ma, 32'h8000_0000);
            rc(ma, 32'h8000_0000);
            ev(k, 32'h1);
            repeat (3) @(posedge clk_i);
            @(negedge clk_i);
            chk(summ, 32'h0);
            @(posedge clk_i);
            ev(k, 32'h8000_0000);
            repeat (6) @(posedge clk_i);
            @(negedge clk_i);
            chk(summ, 32'h1 << sb);
            @(posedge clk_i);
            rc(ma - 9'h4, e);
            @(negedge clk_i);
            chk(summ, 32'h0);
            @(posedge clk_i);
            wr(ma, 32'h0);
        end
    endtask

    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", tests_run, err_total);
            if (err_total == 0 && tests_run > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask

    // the whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_i);
        err_total = err_total + 1;
        tally_and_finish;
    end

    initial begin
        repeat (6) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        s_reset;
        s_qev;
        s_ovu;
        s_roll;
        s_race;
        s_freeze;
        s_mask(9'h1c4, 3'd0, 5'd19, 32'hc000_000c);
        s_mask(9'h1cc, 3'd1, 5'd18, 32'h8000_0008);
        s_mask(9'h1d4, 3'd3, 5'd16, 32'h8000_0001);
        s_mask(9'h1dc, 3'd4, 5'd16, 32'h8000_0001);
        tally_and_finish;
    end
endmodule // qcis_top_tb
